// File: common/vsc_pkg.sv
// Shared constants for the video switch serial configuration register bank.
package vsc_pkg;
  localparam int VSC_NUM_REGS = 8;
  localparam int VSC_IDX_W = 3;
  // Register offsets on the serial bus.
  localparam logic [7:0] VSC_OFS_FAST_MODE = 8'h00;
  localparam logic [7:0] VSC_OFS_SIDE_MODE = 8'h01;
  localparam logic [7:0] VSC_OFS_RX_SET = 8'h10;
  localparam logic [7:0] VSC_OFS_PULSE_LO = 8'h11;
  localparam logic [7:0] VSC_OFS_PULSE_HI = 8'h12;
  localparam logic [7:0] VSC_OFS_EQ_LO = 8'h13;
  localparam logic [7:0] VSC_OFS_EQ_HI = 8'h14;
  localparam logic [7:0] VSC_OFS_TX_SET = 8'h20;
  // Storage index of each register.
  localparam logic [2:0] VSC_IDX_FAST_MODE = 3'h0;
  localparam logic [2:0] VSC_IDX_SIDE_MODE = 3'h1;
  localparam logic [2:0] VSC_IDX_RX_SET = 3'h2;
  localparam logic [2:0] VSC_IDX_PULSE_LO = 3'h3;
  localparam logic [2:0] VSC_IDX_PULSE_HI = 3'h4;
  localparam logic [2:0] VSC_IDX_EQ_LO = 3'h5;
  localparam logic [2:0] VSC_IDX_EQ_HI = 3'h6;
  localparam logic [2:0] VSC_IDX_TX_SET = 3'h7;
  // Reset values and writable bit masks, by index.
  localparam logic [7:0] VSC_RESET_VAL [VSC_NUM_REGS] =
    '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] VSC_WR_MASK [VSC_NUM_REGS] =
    '{8'h43, 8'h43, 8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f};
  // Field positions.
  localparam int VSC_BIT_ENABLE = 6;
  localparam int VSC_BIT_RX_TERM = 0;
  localparam int VSC_BIT_OUT_CUR = 0;
  localparam int VSC_BIT_OUT_TERM = 1;
  localparam int VSC_BIT_BOOST_LO = 2;
  // Side mode and receive setting images while the parallel pins are in charge.
  localparam logic [7:0] VSC_PAR_SIDE_BASE = 8'h40;
  localparam logic [7:0] VSC_PAR_RX_IMG = 8'h01;
  // Upper slave address bits; the value is arbitrary.
  localparam logic [3:0] VSC_ID_UPPER = 4'h5;
  // Timing: core clock and documented/assumed delays.
  localparam int VSC_CLK_MHZ = 200;
  localparam int VSC_TERM_PULSE_MS = 100;
  localparam int VSC_UPDATE_DELAY_US = 50;
  localparam int VSC_TERM_PULSE_CYCLES = VSC_TERM_PULSE_MS * 1000 * VSC_CLK_MHZ;
  localparam int VSC_UPDATE_CYCLES = VSC_UPDATE_DELAY_US * VSC_CLK_MHZ;
  localparam logic [3:0] VSC_BITS_PER_BYTE = 4'h8;
  typedef enum logic [8:0] {
    VSC_IDLE = 9'h001,
    VSC_ADDR = 9'h002,
    VSC_ADDR_ACK = 9'h004,
    VSC_REG = 9'h008,
    VSC_REG_ACK = 9'h010,
    VSC_WRITE = 9'h020,
    VSC_WRITE_ACK = 9'h040,
    VSC_READ = 9'h080,
    VSC_READ_ACK = 9'h100
  } vsc_state_t;
endpackage : vsc_pkg

// File: hdl/vsc_config_regs.sv
// Serial configuration register bank of a four-input video link switch.
`timescale 1ns/1ps
// Functional notes
// - External serial master reads and writes the bank; this block is the slave.
// - Three strap pins give the three low slave address bits.
// - After any serial access, parallel pins are ignored until reset.
// - Fast enable 0 turns all fast channels off; 1 turns them on.
// - Fast select 00..11 routes source A..D to the output.
// - Side enable 0 disconnects all low-speed paths; 1 connects selected one.
// - First pulse register holds one pulse bit per channel of A and B.
// - Second pulse register holds one pulse bit per channel of C and D.
// - Channels with pulse bit set lose termination briefly on source switch.
// - Two equalizer registers hold one level bit per input channel.
// - Side select 00..11 connects side source A..D to the common port.
// - Pulse bit 1 disconnects termination for 100 ms from a switch; 0 keeps it.
// - Equalizer bit 0 selects 6 dB, 1 selects 12 dB.
// - Writes inside an update window do not restart it; last value applies.
module vsc_config_regs #(
  parameter int unsigned TERM_PULSE_CYCLES = vsc_pkg::VSC_TERM_PULSE_CYCLES,
  parameter int unsigned UPDATE_CYCLES = vsc_pkg::VSC_UPDATE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic slave_id_strap_2,
  input wire logic slave_id_strap_1,
  input wire logic slave_id_strap_0,
  input wire logic parPathOn,
  input wire logic [1:0] parSourceSel,
  input wire logic parEqLevel,
  input wire logic [1:0] parBoostLevel,
  input wire logic parOutTermOn,
  input wire logic parOutCurrentSel,
  output logic serialMode,
  output logic fast_path_on,
  output logic [1:0] fast_source_sel,
  output logic sidePathOn,
  output logic [1:0] side_source_sel,
  output logic [15:0] input_term_on,
  output logic [15:0] eq_level_sel,
  output logic [1:0] out_boost_level,
  output logic out_term_on,
  output logic out_current_sel
);
  import vsc_pkg::*;

  function automatic logic [VSC_IDX_W:0] regDecode(input logic [7:0] ofs);
    logic [VSC_IDX_W:0] r;
    r = '0;
    if (ofs == VSC_OFS_FAST_MODE) r = {1'b1, VSC_IDX_FAST_MODE};
    else if (ofs == VSC_OFS_SIDE_MODE) r = {1'b1, VSC_IDX_SIDE_MODE};
    else if (ofs == VSC_OFS_RX_SET) r = {1'b1, VSC_IDX_RX_SET};
    else if (ofs == VSC_OFS_PULSE_LO) r = {1'b1, VSC_IDX_PULSE_LO};
    else if (ofs == VSC_OFS_PULSE_HI) r = {1'b1, VSC_IDX_PULSE_HI};
    else if (ofs == VSC_OFS_EQ_LO) r = {1'b1, VSC_IDX_EQ_LO};
    else if (ofs == VSC_OFS_EQ_HI) r = {1'b1, VSC_IDX_EQ_HI};
    else if (ofs == VSC_OFS_TX_SET) r = {1'b1, VSC_IDX_TX_SET};
    return r;
  endfunction : regDecode

  // Pin synchronisers; the first stage feeds only the second.
  logic [1:0] busMeta_r, busSync_r, busDly_r;
  logic [2:0] strapMeta_r, strapSync_r, strapLatched_r;
  logic strapCaught_r;
  logic [7:0] parMeta_r, parSync_r;
  always_ff @(posedge ref_clk) begin
    busMeta_r <= {sclIn, sdaIn};
    busSync_r <= busMeta_r;
    busDly_r <= busSync_r;
    strapMeta_r <= {slave_id_strap_2, slave_id_strap_1, slave_id_strap_0};
    strapSync_r <= strapMeta_r;
    parMeta_r <= {parPathOn, parSourceSel, parEqLevel, parBoostLevel, parOutTermOn,
                  parOutCurrentSel};
    parSync_r <= parMeta_r;
  end

  // Straps are caught once after reset so a moving strap cannot alter the address mid-frame.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strapCaught_r <= 1'b0;
      strapLatched_r <= 3'h0;
    end else if (!strapCaught_r) begin
      strapCaught_r <= 1'b1;
      strapLatched_r <= strapSync_r;
    end
  end

  wire sclHi = busSync_r[1];
  wire sdaLv = busSync_r[0];
  wire sclRise = busSync_r[1] & ~busDly_r[1];
  wire sclFall = ~busSync_r[1] & busDly_r[1];
  wire busStart = sclHi & busDly_r[1] & ~sdaLv & busDly_r[0];
  wire busStop = sclHi & busDly_r[1] & sdaLv & ~busDly_r[0];

  vsc_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rxShift_r, txShift_r, regPtr_r;
  logic readMode_r, serialUsed_r, masterNack_r;
  logic [7:0] shadow_r [VSC_NUM_REGS];
  logic [7:0] applied_r [VSC_NUM_REGS];
  logic [31:0] windowCnt_r;

  wire byteDone = sclFall & (bitCnt_r == VSC_BITS_PER_BYTE);
  wire addrMatch = rxShift_r[7:1] == {VSC_ID_UPPER, strapLatched_r};
  wire [VSC_IDX_W:0] ptrDec = regDecode(regPtr_r);
  wire ptrValid = ptrDec[VSC_IDX_W];
  wire [VSC_IDX_W-1:0] ptrIdx = ptrDec[VSC_IDX_W-1:0];
  wire [7:0] readData = ptrValid ? shadow_r[ptrIdx] : 8'h00;
  wire wrStrobe = (state_r == VSC_WRITE) & byteDone;
  wire windowActive = windowCnt_r != 32'h0;
  wire windowEnd = windowCnt_r == 32'h1;

  // Serial slave: data changes only while the clock is low, sampled on its rise.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= VSC_IDLE;
      bitCnt_r <= 4'h0;
      rxShift_r <= 8'h00;
      txShift_r <= 8'h00;
      regPtr_r <= 8'h00;
      readMode_r <= 1'b0;
      masterNack_r <= 1'b0;
      sdaOe <= 1'b0;
    end else if (busStop) begin
      state_r <= VSC_IDLE;
      sdaOe <= 1'b0;
    end else if (busStart) begin
      state_r <= VSC_ADDR;
      bitCnt_r <= 4'h0;
      sdaOe <= 1'b0;
    end else begin
      case (state_r)
        VSC_ADDR, VSC_REG, VSC_WRITE: begin
          if (sclRise) begin
            rxShift_r <= {rxShift_r[6:0], sdaLv};
            bitCnt_r <= bitCnt_r + 4'h1;
          end else if (byteDone) begin
            bitCnt_r <= 4'h0;
            if (state_r == VSC_ADDR) begin
              readMode_r <= rxShift_r[0];
              state_r <= addrMatch ? VSC_ADDR_ACK : VSC_IDLE;
              sdaOe <= addrMatch;
            end else if (state_r == VSC_REG) begin
              regPtr_r <= rxShift_r;
              state_r <= VSC_REG_ACK;
              sdaOe <= 1'b1;
            end else begin
              state_r <= VSC_WRITE_ACK;
              sdaOe <= 1'b1;
            end
          end
        end
        VSC_ADDR_ACK: begin
          if (sclFall) begin
            if (readMode_r) begin
              state_r <= VSC_READ;
              txShift_r <= readData;
              sdaOe <= ~readData[7];
            end else begin
              state_r <= VSC_REG;
              sdaOe <= 1'b0;
            end
          end
        end
        VSC_REG_ACK: begin
          if (sclFall) begin
            state_r <= VSC_WRITE;
            sdaOe <= 1'b0;
          end
        end
        VSC_WRITE_ACK: begin
          if (sclFall) begin
            state_r <= VSC_WRITE;
            regPtr_r <= regPtr_r + 8'h01;
            sdaOe <= 1'b0;
          end
        end
        VSC_READ: begin
          if (sclFall) begin
            if (bitCnt_r == VSC_BITS_PER_BYTE - 4'h1) begin
              state_r <= VSC_READ_ACK;
              bitCnt_r <= 4'h0;
              sdaOe <= 1'b0;
              regPtr_r <= regPtr_r + 8'h01;
            end else begin
              txShift_r <= {txShift_r[6:0], 1'b0};
              sdaOe <= ~txShift_r[6];
              bitCnt_r <= bitCnt_r + 4'h1;
            end
          end
        end
        VSC_READ_ACK: begin
          if (sclRise) begin
            masterNack_r <= sdaLv;
          end else if (sclFall) begin
            state_r <= masterNack_r ? VSC_IDLE : VSC_READ;
            txShift_r <= readData;
            sdaOe <= ~masterNack_r & ~readData[7];
          end
        end
        default: begin
          state_r <= VSC_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end
  assign sdaOut = 1'b0;

  // Any acknowledged address hands control to the serial registers.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      serialUsed_r <= 1'b0;
    end else if ((state_r == VSC_ADDR) & byteDone & addrMatch) begin
      serialUsed_r <= 1'b1;
    end
  end
  assign serialMode = serialUsed_r;

  // One window covers the whole bank; a write outside it applies at once.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      windowCnt_r <= 32'h0;
    end else if (wrStrobe & ptrValid & !windowActive) begin
      windowCnt_r <= UPDATE_CYCLES;
    end else if (windowActive) begin
      windowCnt_r <= windowCnt_r - 32'h1;
    end
  end

  wire [7:0] wrMasked [VSC_NUM_REGS];
  for (genvar i = 0; i < VSC_NUM_REGS; i++) begin : gRegs
    wire hit = wrStrobe & ptrValid & (ptrIdx == VSC_IDX_W'(i));
    assign wrMasked[i] = rxShift_r & VSC_WR_MASK[i];
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        shadow_r[i] <= VSC_RESET_VAL[i];
        applied_r[i] <= VSC_RESET_VAL[i];
      end else begin
        if (hit) begin
          shadow_r[i] <= wrMasked[i];
        end
        if (hit & !windowActive) begin
          applied_r[i] <= wrMasked[i];
        end else if (windowEnd) begin
          // A write on the closing cycle must still be the value that lands.
          applied_r[i] <= hit ? wrMasked[i] : shadow_r[i];
        end
      end
    end
  end

  // Parallel pin images of each register, used until the first serial access.
  wire pEn = parSync_r[7];
  wire [1:0] pSrc = parSync_r[6:5];
  wire [7:0] parImg [VSC_NUM_REGS];
  assign parImg[VSC_IDX_FAST_MODE] = {1'b0, pEn, 4'h0, pSrc};
  assign parImg[VSC_IDX_SIDE_MODE] = VSC_PAR_SIDE_BASE | {6'h00, pSrc};
  assign parImg[VSC_IDX_RX_SET] = VSC_PAR_RX_IMG;
  assign parImg[VSC_IDX_PULSE_LO] = 8'h00;
  assign parImg[VSC_IDX_PULSE_HI] = 8'h00;
  assign parImg[VSC_IDX_EQ_LO] = {8{parSync_r[4]}};
  assign parImg[VSC_IDX_EQ_HI] = {8{parSync_r[4]}};
  assign parImg[VSC_IDX_TX_SET] = {4'h0, parSync_r[3:0]};
  wire [7:0] eff [VSC_NUM_REGS];
  for (genvar i = 0; i < VSC_NUM_REGS; i++) begin : gEff
    assign eff[i] = serialUsed_r ? applied_r[i] : parImg[i];
  end

  wire [7:0] effFast = eff[VSC_IDX_FAST_MODE];
  wire [7:0] effSide = eff[VSC_IDX_SIDE_MODE];
  wire [7:0] effTx = eff[VSC_IDX_TX_SET];
  wire [15:0] pulseSel = {eff[VSC_IDX_PULSE_HI], eff[VSC_IDX_PULSE_LO]};
  wire sourceChange = effFast[1:0] != fast_source_sel;
  logic [31:0] pulseCnt_r;
  wire pulsing = sourceChange | (pulseCnt_r != 32'h0);
  wire [15:0] termNxt = {16{eff[VSC_IDX_RX_SET][VSC_BIT_RX_TERM]}} &
                        ~({16{pulsing}} & pulseSel);

  // Termination pulse timer restarts on every fast source change.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pulseCnt_r <= 32'h0;
    end else if (sourceChange) begin
      pulseCnt_r <= TERM_PULSE_CYCLES - 32'h1;
    end else if (pulseCnt_r != 32'h0) begin
      pulseCnt_r <= pulseCnt_r - 32'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fast_path_on <= 1'b0;
      fast_source_sel <= 2'h0;
      sidePathOn <= 1'b0;
      side_source_sel <= 2'h0;
      input_term_on <= 16'h0000;
      eq_level_sel <= 16'h0000;
      out_boost_level <= 2'h0;
      out_term_on <= 1'b0;
      out_current_sel <= 1'b0;
    end else begin
      fast_path_on <= effFast[VSC_BIT_ENABLE];
      fast_source_sel <= effFast[1:0];
      sidePathOn <= effSide[VSC_BIT_ENABLE];
      side_source_sel <= effSide[1:0];
      input_term_on <= termNxt;
      eq_level_sel <= {eff[VSC_IDX_EQ_HI], eff[VSC_IDX_EQ_LO]};
      out_boost_level <= effTx[VSC_BIT_BOOST_LO+1:VSC_BIT_BOOST_LO];
      out_term_on <= effTx[VSC_BIT_OUT_TERM];
      out_current_sel <= effTx[VSC_BIT_OUT_CUR];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence addrByteMatched;
    (state_r == VSC_ADDR) && byteDone && addrMatch;
  endsequence
  sequence ackDriven;
    (state_r == VSC_ADDR_ACK) && sdaOe;
  endsequence
  a_addr_ack: assert property (addrByteMatched |=> ackDriven)
    else $error("matching address not acknowledged");
  a_serial_sticky: assert property (serialUsed_r |=> serialUsed_r)
    else $error("serial mode dropped without reset");
  a_parallel_ignored: assert property (serialUsed_r |=>
      fast_path_on == $past(applied_r[VSC_IDX_FAST_MODE][VSC_BIT_ENABLE]))
    else $error("fast enable not taken from serial register");
  a_source_route: assert property (!serialUsed_r |=> fast_source_sel == $past(pSrc))
    else $error("fast source does not follow parallel select");
  a_side_route: assert property (1'b1 |=>
      sidePathOn == $past(effSide[VSC_BIT_ENABLE]) && side_source_sel == $past(effSide[1:0]))
    else $error("side switch does not follow its register");
  a_term_pulse: assert property (sourceChange |=>
      (input_term_on & $past(pulseSel)) == 16'h0000)
    else $error("termination not pulsed on source change");
  a_pulse_hold: assert property ((pulseCnt_r > 32'h1) && !sourceChange |=>
      (input_term_on & pulseSel) == 16'h0000 || !$stable(pulseSel))
    else $error("pulsed termination reconnected early");
  a_window_hold: assert property (windowActive && !windowEnd |=>
      applied_r[VSC_IDX_FAST_MODE] == $past(applied_r[VSC_IDX_FAST_MODE]))
    else $error("register applied inside update window");
  a_unmapped_quiet: assert property (wrStrobe && !ptrValid |=>
      shadow_r[VSC_IDX_TX_SET] == $past(shadow_r[VSC_IDX_TX_SET]))
    else $error("unmapped write changed a register");
  a_reset_defaults: assert property (@(posedge ref_clk) disable iff (1'b0) reset |=>
      shadow_r[VSC_IDX_FAST_MODE] == VSC_RESET_VAL[0] && !serialUsed_r)
    else $error("reset default not loaded");
endmodule : vsc_config_regs

// File: sim/vsc_serial_master.sv
// Serial bus master model that drives the clock and data pins of the register bank.
`timescale 1ns/1ps
module vsc_serial_master (
  input wire logic ref_clk,
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLow
);
  initial begin
    sclOut = 1'b1;
    sdaLow = 1'b0;
  end
  // Changes land just after a clock edge, and each phase stays above the slave's minimum.
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : hold
  // Start and repeated start: data falls while the clock is high.
  task automatic start_cond();
    sdaLow = 1'b0;
    hold(4);
    sclOut = 1'b1;
    hold(8);
    sdaLow = 1'b1;
    hold(8);
    sclOut = 0;
    hold(4);
  endtask : start_cond
  // Stop: data rises while the clock is high, then the bus is left released.
  task automatic stop_cond();
    sdaLow = 1'b1;
    hold(4);
    sclOut = 1'b1;
    hold(8);
    sdaLow = 1'b0;
    hold(8);
  endtask : stop_cond
  // The data line is only ever pulled low, so a one is sent by releasing it.
  task automatic bit_io(input logic drv, output logic seen);
    sdaLow = !drv;
    hold(4);
    sclOut = 1'b1;
    hold(4);
    seen = sdaLine;
    hold(4);
    sclOut = 1'b0;
    hold(2);
  endtask : bit_io
  // One byte, most significant bit first, then the acknowledge bit.
  task automatic byte_io(input logic [7:0] tx, input logic masterAck, output logic [7:0] rx,
                         output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(!masterAck, s);
    acked = !s;
  endtask : byte_io
endmodule : vsc_serial_master

// File: sim/vsc_config_regs_tb.sv
// Self-checking testbench for the serial configuration register bank.
`timescale 1ns/1ps
module vsc_config_regs_tb;
  import vsc_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  localparam logic [6:0] DEV = {VSC_ID_UPPER, STRAP};
  localparam logic [7:0] OFS [9] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20, 8'h05};
  localparam logic [7:0] DEF [9] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
  localparam logic [7:0] WR [9] = '{8'hff, 8'hff, 8'hfe, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'hff, 8'hff};
  localparam logic [7:0] RB [9] = '{8'h43, 8'h43, 8'h00, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h0f, 8'h00};
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic parPathOn = 1'b1;
  logic [1:0] parSourceSel = 2'h2;
  logic parEqLevel = 1'b1;
  logic [1:0] parBoostLevel = 2'h1;
  logic parOutTermOn = 1'b0;
  logic parOutCurrentSel = 1'b1;
  logic sclLine, sdaLow, sdaLine, sdaOut, sdaOe, serialMode, fastOn, sideOn, outTerm, curSel;
  logic [1:0] fastSel, sideSel, boost;
  logic [15:0] termOn, eqSel;
  logic [42:0] outs;
  logic [7:0] rd;
  int miscompares = 0;
  int cmpCount = 0;
  always #2.5 ref_clk = ~ref_clk;
  // Open-drain data line with a pull-up: low while either party pulls it.
  assign sdaLine = !(sdaLow || (sdaOe && !sdaOut));
  assign outs = {serialMode, fastOn, fastSel, sideOn, sideSel, termOn, eqSel, boost, outTerm, curSel};
  vsc_serial_master u_vsc_serial_master (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(sclLine),
    .sdaLow(sdaLow));
  vsc_config_regs #(.TERM_PULSE_CYCLES(100), .UPDATE_CYCLES(600)) u_vsc_config_regs (
    .ref_clk(ref_clk), .reset(reset), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .slave_id_strap_2(STRAP[2]), .slave_id_strap_1(STRAP[1]),
    .slave_id_strap_0(STRAP[0]), .parPathOn(parPathOn), .parSourceSel(parSourceSel),
    .parEqLevel(parEqLevel), .parBoostLevel(parBoostLevel), .parOutTermOn(parOutTermOn),
    .parOutCurrentSel(parOutCurrentSel), .serialMode(serialMode), .fast_path_on(fastOn),
    .fast_source_sel(fastSel), .sidePathOn(sideOn), .side_source_sel(sideSel),
    .input_term_on(termOn), .eq_level_sel(eqSel), .out_boost_level(boost),
    .out_term_on(outTerm), .out_current_sel(curSel));
  task automatic compare(input string what, input logic [47:0] seen, input logic [47:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : compare
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic xfer(input logic [7:0] tx, input logic masterAck, input logic expAck);
    logic a;
    u_vsc_serial_master.byte_io(tx, masterAck, rd, a);
    compare("acknowledge", 48'(a), 48'(expAck));
  endtask : xfer
  task automatic reg_write(input logic [7:0] ofs, input logic [15:0] d, input int n);
    u_vsc_serial_master.start_cond();
    xfer({DEV, 1'b0}, 1'b0, 1'b1);
    xfer(ofs, 1'b0, 1'b1);
    for (int i = 0; i < n; i++) begin
      xfer(d[8*i +: 8], 1'b0, 1'b1);
    end
    u_vsc_serial_master.stop_cond();
  endtask : reg_write
  // The final byte is not acknowledged by the master, which ends the read.
  task automatic reg_read(input logic [7:0] ofs);
    u_vsc_serial_master.start_cond();
    xfer({DEV, 1'b0}, 1'b0, 1'b1);
    xfer(ofs, 1'b0, 1'b1);
    u_vsc_serial_master.start_cond();
    xfer({DEV, 1'b1}, 1'b0, 1'b1);
    xfer(8'hff, 1'b0, 1'b0);
    u_vsc_serial_master.stop_cond();
  endtask : reg_read
  initial begin
    repeat (100000) @(posedge ref_clk);
    miscompares++;
    complete_run();
  end
  // Every wait of 650 cycles outlasts the 600-cycle update window, so the outputs have settled.
  initial begin
    tick(6);
    reset = 1'b0;
    tick(650);
    compare("parallel", 48'(outs),
            48'({1'b0, 1'b1, 2'h2, 1'b1, 2'h2, 16'hffff, 16'hffff, 2'h1, 1'b0, 1'b1}));
    for (int i = 0; i < 3; i++) begin
      u_vsc_serial_master.start_cond();
      xfer({DEV ^ 7'(1 << i), 1'b0}, 1'b0, 1'b0);
      u_vsc_serial_master.stop_cond();
    end
    compare("serial mode", 48'(serialMode), 48'h0);
    $display("Test addressing done");
    for (int i = 0; i < 9; i++) begin
      reg_read(OFS[i]);
      compare("default", 48'(rd), 48'(DEF[i]));
    end
    parSourceSel = 2'h1;
    tick(650);
    compare("serial", 48'(outs),
            48'({1'b1, 1'b1, 2'h0, 1'b1, 2'h0, 16'hffff, 16'h0, 2'h0, 1'b1, 1'b1}));
    $display("Test defaults done");
    for (int i = 0; i < 9; i++) begin
      reg_write(OFS[i], 16'(WR[i]), 1);
      reg_read(OFS[i]);
      compare("readback", 48'(rd), 48'(RB[i]));
    end
    tick(650);
    compare("fields", 48'(outs),
            48'({1'b1, 1'b1, 2'h3, 1'b1, 2'h3, 16'h0, 16'hc33c, 2'h3, 1'b1, 1'b1}));
    $display("Test registers done");
    for (int s = 0; s < 4; s++) begin
      reg_write(8'h00, {1'b0, ~s[0], 4'h0, 2'(3 - s), 1'b0, s[0], 4'h0, s[1:0]}, 2);
      tick(650);
      compare("mode", 48'({fastOn, fastSel, sideOn, sideSel}),
              48'({s[0], s[1:0], ~s[0], 2'(3 - s)}));
    end
    $display("Test modes done");
    // The second byte lands inside the window the first one opened.
    reg_write(8'h00, 16'h4241, 2);
    compare("early", 48'({fastSel, sideOn, sideSel}), 48'({2'h1, 1'b0, 2'h0}));
    tick(510);
    compare("window end", 48'({sideOn, sideSel}), 48'({1'b1, 2'h2}));
    $display("Test update window done");
    tick(650);
    reg_write(8'h10, 16'hff01, 2);
    tick(650);
    compare("term idle", 48'(termOn), 48'hffff);
    reg_write(8'h00, 16'h0042, 1);
    compare("term pulse", 48'(termOn), 48'ha500);
    tick(100);
    compare("term back", 48'(termOn), 48'hffff);
    $display("Test termination pulse done");
    complete_run();
  end
endmodule : vsc_config_regs_tb
